// [design/tkd_decoder.sv]
// Touch key command decoder: byte command parser, replies, APB registers
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module tkd_decoder
	import tkd_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_byte,
	output logic             rx_ready,
	output logic             tx_valid,
	output logic [7:0]       tx_byte,
	input  wire logic        tx_ready,
	input  wire logic        cfg_reload,
	input  wire tkd_sense_s  sense,
	output logic             noise_sync_en
);

	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		tkd_state_e state;
		logic       put_mode;
		tkd_scope_e kind;
		logic [3:0] sidx;
		logic [7:0] cmd;
		tkd_rkind_e rkind;
		logic [7:0] fixed;
		logic [5:0] len;
		logic [5:0] pos;
		logic       ns_pend;
		logic       ns_act;
		logic       enable;
		logic [7:0] last_cmd;
		logic       rx_ready;
		logic       tx_valid;
		logic [7:0] tx_byte;
		logic [31:0] prdata;
		logic       pready;
		logic       pslverr;
	} tkd_regs_s;

	tkd_regs_s st_q;
	tkd_regs_s st_d;

	// Registers on the APB map
	typedef enum logic [1:0] {
		RS_NONE   = 2'h0,
		RS_CTRL   = 2'h1,
		RS_STATUS = 2'h2,
		RS_LAST   = 2'h3
	} tkd_rsel_e;

	////////////////////////////////////////////////////////////////////////////
	// Key number of the j-th member of the scope
	function automatic logic [3:0] key_of(tkd_scope_e k, logic [3:0] s, logic [3:0] j);
		logic [3:0] r;
		r = '0;
		case (k)
			SC_KEY:  r = s;
			SC_ROW:  r = {s[1:0], j[1:0]};
			SC_COL:  r = {j[1:0], s[1:0]};
			SC_ALL:  r = j;
			default: r = '0;
		endcase
		return r;
	endfunction

	// Undefined scope behaves as key 0 alone
	function automatic logic [4:0] nkeys(tkd_scope_e k);
		logic [4:0] n;
		n = KEYS_ONE;
		case (k)
			SC_ROW:  n = KEYS_LINE;
			SC_COL:  n = KEYS_LINE;
			SC_ALL:  n = KEYS_ALL;
			default: n = KEYS_ONE;
		endcase
		return n;
	endfunction

	// Reply length of a query; zero means not a query
	function automatic logic [5:0] qlen(logic [7:0] c, tkd_scope_e k);
		logic [5:0] n;
		n = {1'b0, nkeys(k)};
		case (c)
			CMD_SIG1, CMD_REF1:                    qlen = LEN_WORD;
			CMD_DELTA1, CMD_INTEG1, CMD_EESUM,
			CMD_DSTAT, CMD_ERR1, CMD_FIRST:        qlen = LEN_ONE;
			CMD_SIGG, CMD_REFG:                    qlen = 6'(n << 1);
			CMD_DELTAG, CMD_INTEGG:                qlen = n;
			CMD_ERRG, CMD_TOUCHG:
				qlen = (k == SC_ALL) ? LEN_BITS16 : LEN_ONE;
			default:                               qlen = '0;
		endcase
	endfunction

	// Four-bit group of flags, one bit per scoped key
	function automatic logic [7:0] bits_byte(tkd_scope_e k, logic [3:0] s, logic [5:0] p,
			logic [15:0] f);
		logic [7:0] b;
		logic [3:0] kk;
		b = '0;
		kk = '0;
		for (int j = 0; j < 4; j++) begin
			if (k == SC_ALL) begin
				kk = {p[1:0], 2'(j)};
				b[j] = f[kk];
			end else if (5'(j) < nkeys(k)) begin
				kk = key_of(k, s, 4'(j));
				b[j] = f[kk];
			end
		end
		return b;
	endfunction

	// Byte p of the reply to query c, words low byte first
	function automatic logic [7:0] qbyte(logic [7:0] c, tkd_scope_e k, logic [3:0] s,
			logic [5:0] p, tkd_sense_s d);
		logic [3:0]  k1;
		logic [3:0]  kg;
		logic [3:0]  kb;
		logic [15:0] eflag;
		k1 = key_of(k, s, '0);
		kg = key_of(k, s, p[4:1]);
		kb = key_of(k, s, p[3:0]);
		eflag = '0;
		// Error bit per key: any nonzero error code
		for (int i = 0; i < 16; i++) begin
			eflag[i] = |d.err[i];
		end
		case (c)
			CMD_SIG1:   qbyte = p[0] ? d.sig[k1][15:8] : d.sig[k1][7:0];
			CMD_REF1:   qbyte = p[0] ? d.ref_lvl[k1][15:8] : d.ref_lvl[k1][7:0];
			CMD_DELTA1: qbyte = d.delta[k1];
			CMD_INTEG1: qbyte = d.integ[k1];
			CMD_EESUM:  qbyte = d.ee_sum;
			CMD_DSTAT:  qbyte = {3'h0, d.dev_status};
			CMD_SIGG:   qbyte = p[0] ? d.sig[kg][15:8] : d.sig[kg][7:0];
			CMD_REFG:   qbyte = p[0] ? d.ref_lvl[kg][15:8] : d.ref_lvl[kg][7:0];
			CMD_DELTAG: qbyte = d.delta[kb];
			CMD_INTEGG: qbyte = d.integ[kb];
			CMD_ERR1:   qbyte = {4'h0, d.err[k1]};
			CMD_ERRG:   qbyte = bits_byte(k, s, p, eflag);
			CMD_FIRST:  qbyte = d.first_key;
			CMD_TOUCHG: qbyte = bits_byte(k, s, p, d.touch);
			default:    qbyte = '0;
		endcase
	endfunction

	// Register picked by an address; anything else is unmapped
	function automatic tkd_rsel_e reg_sel(logic [11:0] a);
		tkd_rsel_e r;
		r = RS_NONE;
		if (a == ADDR_CTRL) begin
			r = RS_CTRL;
		end else if (a == ADDR_STATUS) begin
			r = RS_STATUS;
		end else if (a == ADDR_LAST) begin
			r = RS_LAST;
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	logic        rx_take;
	logic        apb_done;
	logic [5:0]  rx_qlen;
	logic [31:0] status_word;
	tkd_rsel_e   rsel;
	logic        ctrl_wr;

	assign rx_take  = rx_valid && st_q.rx_ready;
	assign apb_done = psel && penable && st_q.pready;
	assign rx_qlen  = qlen(rx_byte, st_q.kind);
	assign rsel     = reg_sel(paddr);
	// Write lands at the edge that sees pready, never in setup
	assign ctrl_wr  = apb_done && pwrite && (rsel == RS_CTRL);

	// Busy tells software a reply is still draining
	always_comb begin
		status_word = '0;
		status_word[ST_PUT_BIT] = st_q.put_mode;
		status_word[ST_KIND_LSB +: 3] = st_q.kind;
		status_word[ST_IDX_LSB +: 4] = st_q.sidx;
		status_word[ST_NSP_BIT] = st_q.ns_pend;
		status_word[ST_NSA_BIT] = st_q.ns_act;
		status_word[ST_BUSY_BIT] = (st_q.state == ST_SEND);
	end

	always_comb begin
		st_d = st_q;

		// Command stream
		case (st_q.state)
			ST_IDLE: begin
				if (rx_take) begin
					st_d.last_cmd = rx_byte;
					st_d.cmd = rx_byte;
					st_d.rkind = RK_FIXED;
					st_d.fixed = rx_byte;
					st_d.len = LEN_ONE;
					st_d.pos = '0;
					if (rx_byte == CMD_GET) begin
						st_d.put_mode = 1'b0;
						st_d.state = ST_SEND;
					end else if (rx_byte == CMD_PUT) begin
						st_d.put_mode = 1'b1;
						st_d.state = ST_SEND;
					end else if (rx_byte == CMD_SC_ALL) begin
						st_d.kind = SC_ALL;
						st_d.sidx = '0;
						st_d.state = ST_SEND;
					end else if (rx_byte == CMD_NSYNC && !st_q.put_mode) begin
						st_d.fixed = {7'h00, st_q.ns_pend};
						st_d.state = ST_SEND;
					end else if (rx_byte == CMD_NSYNC || rx_byte == CMD_SC_KEY ||
							rx_byte == CMD_SC_ROW || rx_byte == CMD_SC_COL) begin
						st_d.state = ST_OPND;
					end else if (rx_qlen != '0) begin
						st_d.rkind = RK_QUERY;
						st_d.len = rx_qlen;
						st_d.state = ST_SEND;
					end
				end
			end
			ST_OPND: begin
				// A bad operand is dropped silently and no echo follows
				if (rx_take) begin
					st_d.state = ST_IDLE;
					if (st_q.cmd == CMD_NSYNC) begin
						if (rx_byte == NS_OFF || rx_byte == NS_ON) begin
							st_d.ns_pend = rx_byte[0];
							st_d.state = ST_SEND;
						end
					end else if (st_q.cmd == CMD_SC_KEY) begin
						if (rx_byte <= MAX_KEY) begin
							st_d.kind = SC_KEY;
							st_d.sidx = rx_byte[3:0];
							st_d.state = ST_SEND;
						end
					end else if (rx_byte <= MAX_LINE) begin
						st_d.kind = (st_q.cmd == CMD_SC_ROW) ? SC_ROW : SC_COL;
						st_d.sidx = {2'h0, rx_byte[1:0]};
						st_d.state = ST_SEND;
					end
				end
			end
			ST_SEND: begin
				// Parser stays deaf until the last reply byte leaves
				if (st_q.tx_valid && tx_ready) begin
					st_d.tx_valid = 1'b0;
					st_d.pos = st_q.pos + 6'h01;
					if (st_q.pos + 6'h01 == st_q.len) begin
						st_d.state = ST_IDLE;
					end
				end else if (!st_q.tx_valid) begin
					st_d.tx_valid = 1'b1;
					st_d.tx_byte = (st_q.rkind == RK_QUERY) ?
						qbyte(st_q.cmd, st_q.kind, st_q.sidx, st_q.pos, sense) : st_q.fixed;
				end
			end
			default: st_d.state = ST_IDLE;
		endcase
		// Ready drops with the byte that starts a reply, so nothing slips in
		st_d.rx_ready = st_q.enable && (st_d.state != ST_SEND);

		// Stored value goes live on a reset command or on a CTRL write with the apply bit
		if (cfg_reload) begin
			st_d.ns_act = st_q.ns_pend;
		end

		// APB slave with one wait state
		st_d.pready = 1'b0;
		st_d.pslverr = 1'b0;
		if (psel && penable && !st_q.pready) begin
			st_d.pready = 1'b1;
			st_d.prdata = '0;
			// Unmapped reads return zero with the error flag
			if (rsel == RS_CTRL) begin
				st_d.prdata[CTRL_EN_BIT] = st_q.enable;
			end else if (rsel == RS_STATUS) begin
				st_d.prdata = status_word;
			end else if (rsel == RS_LAST) begin
				st_d.prdata = {24'h000000, st_q.last_cmd};
			end else begin
				st_d.pslverr = 1'b1;
			end
		end
		if (ctrl_wr) begin
			st_d.enable = pwdata[CTRL_EN_BIT];
			st_d.rx_ready = pwdata[CTRL_EN_BIT] && (st_d.state != ST_SEND);
			// Copies the pending value including an operand taken this cycle; the reset command copies the registered one
			if (pwdata[CTRL_APPLY_BIT]) begin
				st_d.ns_act = st_d.ns_pend;
			end
		end
	end

	// Reset image: Get mode, no scope, noise sync off, port enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '{
				state:    ST_IDLE,
				put_mode: 1'b0,
				kind:     SC_NONE,
				sidx:     4'h0,
				cmd:      8'h00,
				rkind:    RK_FIXED,
				fixed:    8'h00,
				len:      6'h00,
				pos:      6'h00,
				ns_pend:  NS_RESET,
				ns_act:   NS_RESET,
				enable:   CTRL_EN_RESET,
				last_cmd: 8'h00,
				rx_ready: 1'b0,
				tx_valid: 1'b0,
				tx_byte:  8'h00,
				prdata:   32'h00000000,
				pready:   1'b0,
				pslverr:  1'b0
			};
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Every output comes straight from a state register
	assign prdata        = st_q.prdata;
	assign pready        = st_q.pready;
	assign pslverr       = st_q.pslverr;
	assign rx_ready      = st_q.rx_ready;
	assign tx_valid      = st_q.tx_valid;
	assign tx_byte       = st_q.tx_byte;
	assign noise_sync_en = st_q.ns_act;

endmodule // tkd_decoder

// [design/tkd_pkg.sv]
// Package: codes, layouts and types of the touch key command decoder
package tkd_pkg;

	// Command codes
	localparam logic [7:0] CMD_NSYNC    = 8'h17;
	localparam logic [7:0] CMD_GET      = 8'h67;
	localparam logic [7:0] CMD_PUT      = 8'h70;
	localparam logic [7:0] CMD_SC_KEY   = 8'h73;
	localparam logic [7:0] CMD_SC_ALL   = 8'h53;
	localparam logic [7:0] CMD_SC_ROW   = 8'h78;
	localparam logic [7:0] CMD_SC_COL   = 8'h79;
	localparam logic [7:0] CMD_SIG1     = 8'h30;
	localparam logic [7:0] CMD_DELTA1   = 8'h31;
	localparam logic [7:0] CMD_REF1     = 8'h32;
	localparam logic [7:0] CMD_INTEG1   = 8'h35;
	localparam logic [7:0] CMD_EESUM    = 8'h36;
	localparam logic [7:0] CMD_DSTAT    = 8'h37;
	localparam logic [7:0] CMD_SIGG     = 8'h20;
	localparam logic [7:0] CMD_DELTAG   = 8'h21;
	localparam logic [7:0] CMD_REFG     = 8'h22;
	localparam logic [7:0] CMD_INTEGG   = 8'h25;
	localparam logic [7:0] CMD_ERR1     = 8'h65;
	localparam logic [7:0] CMD_ERRG     = 8'h45;
	localparam logic [7:0] CMD_FIRST    = 8'h6B;
	localparam logic [7:0] CMD_TOUCHG   = 8'h4B;

	// Operand limits
	localparam logic [7:0] MAX_KEY      = 8'h0F;
	localparam logic [7:0] MAX_LINE     = 8'h03;
	localparam logic [7:0] NS_OFF       = 8'h00;
	localparam logic [7:0] NS_ON        = 8'h01;
	localparam logic       NS_RESET     = 1'b0;

	// Reply lengths in bytes and key counts of the scopes
	localparam logic [5:0] LEN_ONE      = 6'h01;
	localparam logic [5:0] LEN_WORD     = 6'h02;
	localparam logic [5:0] LEN_BITS16   = 6'h04;
	localparam logic [4:0] KEYS_ONE     = 5'h01;
	localparam logic [4:0] KEYS_LINE    = 5'h04;
	localparam logic [4:0] KEYS_ALL     = 5'h10;

	// APB map
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_LAST   = 12'h008;
	localparam int CTRL_EN_BIT    = 0;
	localparam int CTRL_APPLY_BIT = 1;
	localparam int ST_PUT_BIT     = 0;
	localparam int ST_KIND_LSB    = 1;
	localparam int ST_IDX_LSB     = 4;
	localparam int ST_NSP_BIT     = 8;
	localparam int ST_NSA_BIT     = 9;
	localparam int ST_BUSY_BIT    = 10;
	localparam logic CTRL_EN_RESET = 1'b1;

	typedef enum logic [2:0] {
		SC_NONE = 3'h0,
		SC_KEY  = 3'h1,
		SC_ROW  = 3'h2,
		SC_COL  = 3'h3,
		SC_ALL  = 3'h4
	} tkd_scope_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_OPND = 2'h1,
		ST_SEND = 2'h2
	} tkd_state_e;

	typedef enum logic {
		RK_FIXED = 1'b0,
		RK_QUERY = 1'b1
	} tkd_rkind_e;

	// Live data from the sensing engine
	typedef struct packed {
		logic [15:0][15:0] sig;
		logic [15:0][15:0] ref_lvl;
		logic [15:0][7:0]  delta;
		logic [15:0][7:0]  integ;
		logic [15:0][3:0]  err;
		logic [15:0]       touch;
		logic [7:0]        first_key;
		logic [4:0]        dev_status;
		logic [7:0]        ee_sum;
	} tkd_sense_s;

endpackage

// [tb/tkd_host_model.sv]
// Host side model: sends command bytes, collects reply bytes
`timescale 1ns/1ns
module tkd_host_model
	import tkd_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	output logic            rx_valid,
	output logic [7:0]      rx_byte,
	input  wire logic       rx_ready,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_byte,
	output logic            tx_ready
);
	logic [7:0] q[$];
	logic       slow = 1'b0;
	int         sd = 4;
	initial begin
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		tx_ready = 1'b0;
	end
	// Random stalls keep the reply path honest
	always @(posedge pclk) begin
		if (presetn && tx_valid && tx_ready)
			q.push_back(tx_byte);
		tx_ready <= slow ? 1'($random(sd)) : 1'b1;
	end
	// Released byte shows its inverse, not the last value
	task send(input logic [7:0] b);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_byte <= b;
		@(posedge pclk);
		while (rx_ready !== 1'b1)
			@(posedge pclk);
		rx_valid <= 1'b0;
		rx_byte <= ~b;
	endtask
endmodule // tkd_host_model

// [tb/tkd_decoder_props.sv]
// Checker: port-level properties of the touch key command decoder
`timescale 1ns/1ns
module tkd_decoder_props
	import tkd_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        rx_valid,
	input wire logic [7:0]  rx_byte,
	input wire logic        rx_ready,
	input wire logic        tx_valid,
	input wire logic [7:0]  tx_byte,
	input wire logic        tx_ready,
	input wire logic        cfg_reload,
	input wire logic        noise_sync_en
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_echo(logic [7:0] c);
		rx_valid && rx_ready && rx_byte == c |-> ##2 tx_valid && tx_byte == c;
	endproperty
	////////////////////////////////////////////////////////////////////////////////
	a_get_echo: assert property (p_echo(CMD_GET)) else $error("get echo wrong");
	a_put_echo: assert property (p_echo(CMD_PUT)) else $error("put echo wrong");
	a_all_echo: assert property (p_echo(CMD_SC_ALL)) else $error("all echo wrong");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
		else $error("reply byte dropped");
	a_rx_blocked: assert property (tx_valid |-> !rx_ready)
		else $error("byte taken while sending");
	// Active setting moves only on reload or apply
	a_ns_stable: assert property (!cfg_reload && !(psel && penable && pready && pwrite
		&& paddr == ADDR_CTRL && pwdata[CTRL_APPLY_BIT]) |=> $stable(noise_sync_en))
		else $error("noise sync changed early");
	a_apb_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("apb wait state wrong");
	a_apb_err: assert property (psel && penable && pready && paddr[1:0] == 2'b00
		|-> pslverr == (paddr > ADDR_LAST)) else $error("apb error flag wrong");
	c_reply: cover property (tx_valid && tx_ready);
	c_reload: cover property (cfg_reload);
	c_slverr: cover property (pready && pslverr);
endmodule // tkd_decoder_props
bind tkd_decoder tkd_decoder_props tkd_decoder_props_inst(.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .pslverr, .rx_valid, .rx_byte, .rx_ready, .tx_valid,
	.tx_byte, .tx_ready, .cfg_reload, .noise_sync_en);

// [tb/tkd_decoder_bench.sv]
// Bench: random and corner stimulus for the touch key command decoder
`timescale 1ns/1ns
module tkd_decoder_bench
	import tkd_pkg::*;
;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cfg_reload = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er, rx_valid, rx_ready, tx_valid, tx_ready, noise_sync_en;
	logic [7:0]  rx_byte, tx_byte, e[$];
	tkd_sense_s  sense = '0;
	logic [$bits(tkd_sense_s)-1:0] sv;
	int          seed = 4, n_fail = 0, total_checks = 0, cyc = 0, sk = 1, si = 0, idx;
	logic [7:0]  qs[14] = '{CMD_SIG1, CMD_DELTA1, CMD_REF1, CMD_INTEG1, CMD_EESUM, CMD_DSTAT,
		CMD_SIGG, CMD_DELTAG, CMD_REFG, CMD_INTEGG, CMD_ERR1, CMD_ERRG, CMD_FIRST, CMD_TOUCHG};
	logic [7:0]  sc[4] = '{CMD_SC_KEY, CMD_SC_ROW, CMD_SC_COL, CMD_SC_ALL};
	always #4 pclk = ~pclk;
	tkd_decoder tkd_decoder_inst(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .rx_valid, .rx_byte, .rx_ready, .tx_valid, .tx_byte,
		.tx_ready, .cfg_reload, .sense, .noise_sync_en);
	tkd_host_model tkd_host_model_inst(.pclk, .presetn, .rx_valid, .rx_byte, .rx_ready,
		.tx_valid, .tx_byte, .tx_ready);
	////////////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task final_report;
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			final_report;
		end
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Reply must be fully drained before the next command goes out
	task cmd(input logic [7:0] a, input bit two, input logic [7:0] b);
		tkd_host_model_inst.send(a);
		if (two)
			tkd_host_model_inst.send(b);
		for (int t = 0; t < 400 && tkd_host_model_inst.q.size() < e.size(); t++)
			@(posedge pclk);
		repeat (6) @(posedge pclk);
		check(tkd_host_model_inst.q.size(), e.size());
		foreach (e[i])
			if (i < tkd_host_model_inst.q.size())
				check(tkd_host_model_inst.q[i], e[i]);
		tkd_host_model_inst.q = {};
	endtask
	////////////////////////////////////////////////////////////////////////////////
	function automatic int kx(int i);
		return sk == 1 ? si : sk == 2 ? 4 * si + i : sk == 3 ? si + 4 * i : i;
	endfunction
	function automatic void w16(logic [15:0] v);
		e.push_back(v[7:0]);
		e.push_back(v[15:8]);
	endfunction
	function automatic void mk(logic [7:0] c);
		int n;
		int k;
		logic [7:0] v;
		n = 1;
		if (c == CMD_SIGG || c == CMD_REFG || c == CMD_DELTAG || c == CMD_INTEGG)
			n = sk == 4 ? 16 : sk == 1 ? 1 : 4;
		e = {};
		for (int i = 0; i < n; i++) begin
			k = kx(i);
			case (c)
				CMD_SIG1, CMD_SIGG: w16(sense.sig[k]);
				CMD_REF1, CMD_REFG: w16(sense.ref_lvl[k]);
				CMD_DELTA1, CMD_DELTAG: e.push_back(sense.delta[k]);
				CMD_INTEG1, CMD_INTEGG: e.push_back(sense.integ[k]);
				CMD_ERR1: e.push_back({4'h0, sense.err[k]});
				CMD_EESUM: e.push_back(sense.ee_sum);
				CMD_DSTAT: e.push_back({3'h0, sense.dev_status});
				CMD_FIRST: e.push_back(sense.first_key);
				default: begin
					for (int b = 0; b < (sk == 4 ? 4 : 1); b++) begin
						v = 8'h00;
						for (int j = 0; j < (sk == 1 ? 1 : 4); j++) begin
							k = sk == 4 ? 4 * b + j : kx(j);
							v[j] = c == CMD_TOUCHG ? sense.touch[k] : |sense.err[k];
						end
						e.push_back(v);
					end
				end
			endcase
		end
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		check(noise_sync_en, 1'b0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		check(rd[ST_NSP_BIT:0], {NS_RESET, 8'h00});
		apb(1'b0, 12'h00C, 32'h0);
		check(er, 1'b1);
		apb(1'b0, ADDR_CTRL, 32'h0);
		check(rd[CTRL_EN_BIT], CTRL_EN_RESET);
		check(er, 1'b0);
		e = {CMD_GET};
		cmd(CMD_GET, 0, 0);
		e = {CMD_PUT};
		cmd(CMD_PUT, 0, 0);
		e = {CMD_SC_KEY};
		cmd(CMD_SC_KEY, 1, 8'h05);
		e = {};
		cmd(CMD_NSYNC, 1, 8'h02);
		e = {CMD_NSYNC};
		cmd(CMD_NSYNC, 1, NS_ON);
		check(noise_sync_en, 1'b0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		check(rd[10:0], 11'h153);
		cfg_reload <= 1'b1;
		@(posedge pclk);
		cfg_reload <= 1'b0;
		@(posedge pclk);
		check(noise_sync_en, 1'b1);
		e = {CMD_GET};
		cmd(CMD_GET, 0, 0);
		e = {NS_ON};
		cmd(CMD_NSYNC, 0, 0);
		e = {};
		cmd(NS_OFF, 0, 0);
		e = {NS_ON};
		cmd(CMD_NSYNC, 0, 0);
		e = {CMD_PUT};
		cmd(CMD_PUT, 0, 0);
		e = {CMD_NSYNC};
		cmd(CMD_NSYNC, 1, NS_OFF);
		check(noise_sync_en, 1'b1);
		apb(1'b1, ADDR_CTRL, 32'h0);
		repeat (3) @(posedge pclk);
		check(rx_ready, 1'b0);
		apb(1'b1, ADDR_CTRL, 32'h3);
		@(posedge pclk);
		check(noise_sync_en, 1'b0);
		e = {};
		cmd(CMD_SC_KEY, 1, 8'h10);
		cmd(CMD_SC_ROW, 1, 8'h04);
		apb(1'b0, ADDR_LAST, 32'h0);
		check(rd, {24'h000000, CMD_SC_ROW});
		check(er, 1'b0);
		// Corner indices first, then random ones
		for (int r = 0; r < 8; r++) begin
			for (int i = 0; i < $bits(sv); i++)
				sv[i] = 1'($random(seed));
			@(posedge pclk);
			sense <= sv;
			tkd_host_model_inst.slow = r[0];
			idx = r < 4 ? 15 : $random(seed);
			sk = r % 4 + 1;
			si = sk == 4 ? 0 : sk == 1 ? idx & 15 : idx & 3;
			e = {sc[sk-1]};
			cmd(sc[sk-1], sk != 4, 8'(si));
			foreach (qs[i]) begin
				mk(qs[i]);
				cmd(qs[i], 0, 0);
			end
		end
		final_report;
	end
endmodule // tkd_decoder_bench
